/* File: core/finger_drive.sv */
`timescale 1ns/1ps
module finger_drive
   import gripper_pkg::*;
(
   input  wire logic clk_in,   // System clock
   input  wire logic rstn_in,  // Async reset, active low
   motion_if.drive   mif       // Motion request and step output
);
   logic [7:0] phase_q;
   logic [8:0] phase_sum;
   logic       step_q;
   logic       dir_q;

   // Speed scales the step rate; code 0x00 still crawls
   assign phase_sum     = {1'b0, phase_q} + {1'b0, mif.speed} + 9'h001;
   assign mif.at_target = (mif.position == mif.target);
   assign mif.step      = step_q;
   assign mif.dir       = dir_q;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         phase_q <= 8'h00;
         step_q  <= 1'b0;
         dir_q   <= 1'b0;
      end else begin
         phase_q <= mif.run ? phase_sum[7:0] : 8'h00;
         // Encoder answers a cycle late, so only one step in flight at a time
         step_q  <= mif.run && !mif.at_target && !step_q && phase_sum[8];
         dir_q   <= (mif.target > mif.position);
      end
   end
endmodule // finger_drive

/* File: core/gripper_command_registers.sv */
`timescale 1ns/1ps
// Functional notes
// - Activate bit 1 starts activation; 0 resets gripper and clears non-major faults.
// - Rising activate starts finger motion for activation without go-to.
// - After power-up activate reads set; needs clear then set to operate.
// - Controller keeps activate high; all other actions refused while low.
// - Only activation and release move fingers without the go-to bit.
// - Release drives slowly to the limit, then faults and blocks motion.
// - Release overrides go-to and settings; only activate overrides release.
// - Direction bit 0 closes, 1 opens; latched when release starts.
// - Byte 3 is target position, 0x00 open to 0xFF closed.
// - Speed byte acts in real time; writing it never starts motion.
// - Force byte caps current; exceeding it in go-to motion stops fingers, flags object.
// - Bytes numbered from zero; fixed output and input byte layouts.
// - Major fault held until rising edge of activate bit.
// - Force zero disables re-grasp; non-zero force enables it.
module gripper_command_registers
   import gripper_pkg::*;
(
   input  wire logic       clk_in,          // 40 MHz system clock
   input  wire logic       rstn_in,         // Async reset, active low
   input  wire logic       wr_en_in,        // Write strobe, output area
   input  wire logic       rd_en_in,        // Read strobe, input area
   input  wire logic [3:0] addr_in,         // Byte number 0..15
   input  wire logic [7:0] wdata_in,        // Write data
   input  wire logic [7:0] position_in,     // Encoder finger position
   input  wire logic [7:0] current_in,      // Motor current reading
   input  wire logic       limit_in,        // Mechanical limit switch pin
   output logic      [7:0] rdata_out,       // Read data
   output logic            rvalid_out,      // Read data valid pulse
   output logic            motor_step_out,  // Step pulse to motor stage
   output logic            motor_dir_out,   // 1 closes, 0 opens
   output logic            motor_on_out,    // Motor stage enabled
   output logic      [7:0] current_cap_out  // Current ceiling to motor stage
);

   // ------------------------------------------------------------
   // Output area
   // ------------------------------------------------------------
   logic        act_q, act_prev_q, go_q, rel_q, dir_q;
   logic [7:0]  target_q, speed_q, force_q;
   logic        limit_m_q, limit_s_q;
   grip_state_t state_q, state_d;
   logic [3:0]  fault_q, fault_d;
   logic [1:0]  obj_q, obj_d;
   logic        rel_dir_q, contact_q, contact_d;
   logic [7:0]  rdata_q, rd_mux;
   logic        rvalid_q, motor_on_q;
   motion_if    mif ();

   wire wr_action = wr_en_in && (addr_in == OUT_ACTION_ADDR);
   wire wr_target = wr_en_in && (addr_in == OUT_TARGET_ADDR);
   wire wr_speed  = wr_en_in && (addr_in == OUT_SPEED_ADDR);
   wire wr_force  = wr_en_in && (addr_in == OUT_FORCE_ADDR);

   // Only activate, go, release and direction are kept; other bits dropped
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         act_q    <= ACT_RST;
         go_q     <= 1'b0;
         rel_q    <= 1'b0;
         dir_q    <= 1'b0;
         target_q <= TARGET_RST;
         speed_q  <= SPEED_RST;
         force_q  <= FORCE_RST;
      end else begin
         if (wr_action) begin
            act_q <= wdata_in[ACT_BIT];
            go_q  <= wdata_in[GO_BIT];
            rel_q <= wdata_in[RELEASE_BIT];
            dir_q <= wdata_in[DIR_BIT];
         end
         if (wr_target) target_q <= wdata_in;
         if (wr_speed)  speed_q  <= wdata_in;
         if (wr_force)  force_q  <= wdata_in;
      end
   end

   // ------------------------------------------------------------
   // Limit pin synchroniser and activate edge
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         limit_m_q  <= 1'b0;
         limit_s_q  <= 1'b0;
         act_prev_q <= ACT_RST;
      end else begin
         limit_m_q  <= limit_in;
         limit_s_q  <= limit_m_q;
         act_prev_q <= act_q;
      end
   end

   // Previous value resets high, so the power-up set bit gives no edge
   wire act_rise = act_q && !act_prev_q;
   wire major    = (fault_q == FLT_RELEASING) || (fault_q == FLT_RELEASED);
   // Switch alone misleads: it still reads set at the stop being left
   wire at_stop  = limit_s_q && mif.at_target;

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      if (!act_q) begin
         state_d = st_reset;
      end else begin
         case (state_q)
            st_reset:      if (act_rise) state_d = st_activating;
            st_activating: if (rel_q) state_d = st_releasing;
                           else if (at_stop) state_d = st_ready;
            st_ready:      if (rel_q) state_d = st_releasing;
            st_releasing:  if (at_stop) state_d = st_released;
            st_released:   state_d = st_released;
            default:       state_d = st_reset;
         endcase
      end
   end

   // Direction is latched on entry only; later writes must not steer it
   wire rel_start = (state_d == st_releasing) && (state_q != st_releasing);

   // Major codes survive a low activate and clear only on its rising edge
   always_comb begin
      fault_d = fault_q;
      if (act_rise) begin
         fault_d = FLT_NONE;
      end else if (!act_q) begin
         if (!major) fault_d = go_q ? FLT_NO_ACT : FLT_NONE;
      end else if (rel_start) begin
         fault_d = FLT_RELEASING;
      end else if (state_q == st_releasing && at_stop) begin
         fault_d = FLT_RELEASED;
      end else if (!major) begin
         fault_d = (state_q == st_activating && go_q) ? FLT_DELAYED : FLT_NONE;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_q   <= st_reset;
         fault_q   <= FLT_NONE;
         rel_dir_q <= 1'b0;
      end else begin
         state_q <= state_d;
         fault_q <= fault_d;
         if (rel_start) rel_dir_q <= dir_q;
      end
   end

   // ------------------------------------------------------------
   // Motion selection
   // ------------------------------------------------------------
   // Go-to keeps the motor on at the target; it drops on contact or go low

   wire goto_active = (state_q == st_ready) && go_q;
   wire over_limit  = (current_in > force_q);
   wire releasing   = (state_q == st_releasing);

   // Release target: direction 0 closes, 1 opens
   assign mif.run = (state_q == st_activating) || releasing
                    || (goto_active && !contact_q);
   assign mif.target = releasing ? (rel_dir_q ? POS_OPEN : POS_CLOSED)
                     : (state_q == st_activating) ? POS_OPEN : target_q;
   assign mif.speed    = releasing ? SPEED_SLOW : speed_q;
   assign mif.position = position_in;

   finger_drive u_drive (
      .clk_in  (clk_in),
      .rstn_in (rstn_in),
      .mif     (mif)
   );

   // Contact stop; re-grasp resumes once current drops, unless force is 0
   always_comb begin
      contact_d = contact_q;
      if (!goto_active || wr_action) begin
         contact_d = 1'b0;
      end else if (over_limit && !mif.at_target) begin
         contact_d = 1'b1;
      end else if (contact_q && force_q != 8'h00 && !mif.at_target) begin
         contact_d = 1'b0;
      end
   end

   always_comb begin
      obj_d = OBJ_MOVING;
      if (goto_active) begin
         if (mif.at_target) obj_d = OBJ_AT;
         else if (contact_q) obj_d = mif.dir ? OBJ_CLOSE : OBJ_OPEN;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         contact_q   <= 1'b0;
         obj_q       <= OBJ_MOVING;
         motor_on_q  <= 1'b0;
      end else begin
         contact_q   <= contact_d;
         obj_q       <= obj_d;
         motor_on_q  <= mif.run;
      end
   end

   // ------------------------------------------------------------
   // Input area read port
   // ------------------------------------------------------------
   wire [1:0] sta = (state_q == st_activating) ? STA_BUSY
                  : (state_q == st_ready) ? STA_DONE : STA_RESET;
   wire [7:0] state_byte = ({6'h00, obj_q} << OBJ_LSB) | ({6'h00, sta} << STA_LSB)
                         | ({7'h00, go_q} << GO_BIT) | ({7'h00, act_q} << ACT_BIT);

   always_comb begin
      case (addr_in)
         IN_STATE_ADDR:    rd_mux = state_byte;
         IN_FAULT_ADDR:    rd_mux = {4'h0, fault_q};
         IN_ECHO_ADDR:     rd_mux = target_q;
         IN_POSITION_ADDR: rd_mux = position_in;
         IN_CURRENT_ADDR:  rd_mux = current_in;
         default:          rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rdata_q  <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= rd_en_in;
         if (rd_en_in) rdata_q <= rd_mux;
      end
   end

   assign rdata_out       = rdata_q;
   assign rvalid_out      = rvalid_q;
   assign motor_step_out  = mif.step;
   assign motor_dir_out   = mif.dir;  // Same flop edge as each step
   assign motor_on_out    = motor_on_q;
   assign current_cap_out = force_q;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   a_clear_resets: assert property (!act_q |=> state_q == st_reset)
      else $error("activate low did not reset sequencer");
   a_rise_activates: assert property (act_rise |=> state_q == st_activating
                                      && fault_q == FLT_NONE && mif.run)
      else $error("activate edge did not start activation");
   a_powerup_locked: assert property (state_q == st_reset && act_q && act_prev_q
                                      |=> state_q == st_reset)
      else $error("left reset without activate edge");
   a_inactive_still: assert property (!act_q |=> !mif.run ##1 !motor_on_out)
      else $error("motion while activate low");
   a_motion_cause: assert property (mif.run |-> state_q inside {st_activating,
                                    st_releasing} || (go_q && state_q == st_ready))
      else $error("motion without cause");
   a_release_slow: assert property (releasing |-> mif.speed == SPEED_SLOW
                                    && mif.target == (rel_dir_q ? POS_OPEN : POS_CLOSED))
      else $error("release target or speed wrong");
   a_release_wins: assert property (act_q && rel_q && state_q inside {st_ready,
                                    st_activating} |=> releasing && fault_q == FLT_RELEASING)
      else $error("release request not taken");
   a_release_done: assert property (releasing && act_q && at_stop
                                    |=> state_q == st_released && fault_q == FLT_RELEASED
                                    ##1 !mif.run)
      else $error("release end not flagged");
   a_major_held: assert property (major && !act_rise |=> fault_q == $past(fault_q)
                                  || fault_q == FLT_RELEASED)
      else $error("major fault lost before activate edge");
   a_force_stop: assert property (goto_active && over_limit && !mif.at_target
                                  && !wr_action |=> contact_q)
      else $error("current limit did not stop fingers");
   a_regrasp_off: assert property (contact_q && force_q == 8'h00 && goto_active
                                   && !wr_action && !wr_force |=> contact_q)
      else $error("re-grasp with zero force");
   a_reserved_zero: assert property (rd_en_in && (addr_in == 4'h1 || addr_in > 4'h5)
                                     |=> rvalid_out && rdata_out == 8'h00)
      else $error("reserved byte not zero");
   a_dir_held: assert property (releasing && $past(releasing)
                                |-> rel_dir_q == $past(rel_dir_q))
      else $error("release direction changed midway");
   a_speed_quiet: assert property (wr_speed && !wr_action && !act_rise && !rel_q
                                   && !goto_active && !mif.run |=> !mif.run)
      else $error("speed write started motion");
   // Steps must leave the encoder a cycle to settle
   a_step_spaced: assert property (motor_step_out |=> !motor_step_out)
      else $error("back to back step pulses");

   c_activation: cover property (act_rise ##[1:50] state_q == st_ready);
   c_object_hit: cover property (goto_active ##[1:50] obj_q == OBJ_CLOSE);
   c_release:    cover property (rel_start ##[1:1000] state_q == st_released);
   c_regrasp:    cover property (contact_q ##1 !contact_q && goto_active);
   c_reactivate: cover property (state_q == st_released ##[1:20] act_rise);

endmodule // gripper_command_registers

/* File: core/gripper_pkg.sv */
package gripper_pkg;

   // ------------------------------------------------------------
   // Register map, output area (written) and input area (read)
   // ------------------------------------------------------------
   localparam logic [3:0] OUT_ACTION_ADDR   = 4'h0;
   localparam logic [3:0] OUT_TARGET_ADDR   = 4'h3;
   localparam logic [3:0] OUT_SPEED_ADDR    = 4'h4;
   localparam logic [3:0] OUT_FORCE_ADDR    = 4'h5;
   localparam logic [3:0] IN_STATE_ADDR     = 4'h0;
   localparam logic [3:0] IN_FAULT_ADDR     = 4'h2;
   localparam logic [3:0] IN_ECHO_ADDR      = 4'h3;
   localparam logic [3:0] IN_POSITION_ADDR  = 4'h4;
   localparam logic [3:0] IN_CURRENT_ADDR   = 4'h5;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int ACT_BIT       = 0;
   localparam int GO_BIT        = 3;
   localparam int RELEASE_BIT   = 4;
   localparam int DIR_BIT       = 5;
   localparam int STA_LSB       = 4;
   localparam int OBJ_LSB       = 6;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic       ACT_RST    = 1'b1;
   localparam logic [7:0] TARGET_RST = 8'h00;
   localparam logic [7:0] SPEED_RST  = 8'h00;
   localparam logic [7:0] FORCE_RST  = 8'h00;

   // ------------------------------------------------------------
   // Codes
   // ------------------------------------------------------------
   localparam logic [3:0] FLT_NONE      = 4'h0;
   localparam logic [3:0] FLT_DELAYED   = 4'h5;
   localparam logic [3:0] FLT_NO_ACT    = 4'h7;
   localparam logic [3:0] FLT_RELEASING = 4'hB;
   localparam logic [3:0] FLT_RELEASED  = 4'hF;

   localparam logic [1:0] OBJ_MOVING = 2'h0;
   localparam logic [1:0] OBJ_OPEN   = 2'h1;
   localparam logic [1:0] OBJ_CLOSE  = 2'h2;
   localparam logic [1:0] OBJ_AT     = 2'h3;

   localparam logic [1:0] STA_RESET  = 2'h0;
   localparam logic [1:0] STA_BUSY   = 2'h1;
   localparam logic [1:0] STA_DONE   = 2'h3;

   localparam logic [7:0] POS_OPEN   = 8'h00;
   localparam logic [7:0] POS_CLOSED = 8'hFF;
   localparam logic [7:0] SPEED_SLOW = 8'h00;

   typedef enum logic [4:0] {
      st_reset      = 5'b00001,
      st_activating = 5'b00010,
      st_ready      = 5'b00100,
      st_releasing  = 5'b01000,
      st_released   = 5'b10000
   } grip_state_t;

endpackage

/* File: core/motion_if.sv */
`timescale 1ns/1ps
interface motion_if;
   logic       run;
   logic [7:0] target;
   logic [7:0] speed;
   logic [7:0] position;
   logic       step;
   logic       dir;
   logic       at_target;

   modport ctrl  (output run, target, speed, position, input step, dir, at_target);
   modport drive (input run, target, speed, position, output step, dir, at_target);
endinterface

/* File: tb/finger_model.sv */
`timescale 1ns/1ps
module finger_model (
   input  wire logic       clk_in,       // System clock
   input  wire logic       rstn_in,      // Async reset, active low
   input  wire logic       step_in,      // Step pulse from motor stage
   input  wire logic       dir_in,       // 1 closes, 0 opens
   input  wire logic       obj_en_in,    // Object held between fingers
   input  wire logic [7:0] obj_pos_in,   // Finger position at contact
   output logic      [7:0] position_out, // Encoder reading
   output logic      [7:0] current_out,  // Motor current reading
   output logic            limit_out     // Limit switch, high at a stop
);
   logic pressing;

   // ------------------------------------------------------------
   // Mechanics
   // ------------------------------------------------------------
   assign pressing = obj_en_in && (position_out >= obj_pos_in);
   // Current stays high while pressed, so a stopped grip does not bounce
   assign current_out = pressing ? 8'hF0 : 8'h10;
   assign limit_out = (position_out == 8'h00) || (position_out == 8'hFF);

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         position_out <= 8'h10;
      end else if (step_in) begin
         if (dir_in && !pressing && position_out != 8'hFF) begin
            position_out <= position_out + 8'h01;
         end else if (!dir_in && position_out != 8'h00) begin
            position_out <= position_out - 8'h01;
         end
      end
   end
endmodule // finger_model

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
   import gripper_pkg::*;
   typedef struct {logic chk; logic [7:0] exp; string name;} note_t;
   note_t      notes[$];
   note_t      mon_note;
   logic       clk_in, rstn_in, wr_en, rd_en, obj_en, on_seen;
   logic       rvalid, step, dir, motor_on, limit;
   logic [3:0] addr;
   logic [7:0] wdata, obj_pos, last_rdata, rdata, position, current, cap, tgt;
   logic [31:0] rng;
   int         n_errors = 0;
   int         checked = 0;
   int         k;

   gripper_command_registers u_gripper_command_registers (
      .clk_in(clk_in), .rstn_in(rstn_in), .wr_en_in(wr_en), .rd_en_in(rd_en),
      .addr_in(addr), .wdata_in(wdata), .position_in(position), .current_in(current),
      .limit_in(limit), .rdata_out(rdata), .rvalid_out(rvalid), .motor_step_out(step),
      .motor_dir_out(dir), .motor_on_out(motor_on), .current_cap_out(cap));

   finger_model u_finger_model (
      .clk_in(clk_in), .rstn_in(rstn_in), .step_in(step), .dir_in(dir),
      .obj_en_in(obj_en), .obj_pos_in(obj_pos), .position_out(position),
      .current_out(current), .limit_out(limit));

   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] next();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng[7:0];
   endfunction

   task automatic print_verdict();
      if (n_errors == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_in); #1;
      wr_en = 1'b1;
      addr = a;
      wdata = d;
      @(posedge clk_in); #1;
      wr_en = 1'b0;
   endtask

   // Expected value goes to the queue; the monitor compares it
   task automatic rd(input logic [3:0] a, input logic c, input logic [7:0] e, input string n);
      notes.push_back('{c, e, n});
      @(posedge clk_in); #1;
      rd_en = 1'b1;
      addr = a;
      @(posedge clk_in); #1;
      rd_en = 1'b0;
      @(negedge clk_in); #1;
   endtask

   task automatic poll(input logic [3:0] a, input logic [7:0] m, input logic [7:0] v);
      int i;
      for (i = 0; i < 6000; i++) begin
         rd(a, 1'b0, 8'h00, "");
         if ((last_rdata & m) === v) break;
      end
      chk("poll", v, last_rdata & m);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   task automatic wait_on();
      int i;
      for (i = 0; i < 200 && motor_on !== 1'b1; i++) begin
         @(posedge clk_in);
         #1;
      end
      chk("motor_on", 8'h01, {7'h00, motor_on});
   endtask

   always @(negedge clk_in) begin
      if (motor_on === 1'b1) on_seen = 1'b1;
      if (rvalid === 1'b1) begin
         if (notes.size() == 0) begin
            chk("rvalid", 8'h00, 8'h01);
         end else begin
            mon_note = notes.pop_front();
            last_rdata = rdata;
            if (mon_note.chk) chk(mon_note.name, mon_note.exp, rdata);
         end
      end
   end

   initial begin
      repeat (100000) @(posedge clk_in);
      n_errors++;
      print_verdict();
   end

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      wr_en = 1'b0; rd_en = 1'b0; addr = 4'h0; wdata = 8'h00; obj_en = 1'b0;
      obj_pos = 8'h60; on_seen = 1'b0; rng = 32; rstn_in = 1'b0;
      repeat (5) @(posedge clk_in);
      #1;
      rstn_in = 1'b1;
      rd(IN_STATE_ADDR, 1'b1, 8'h01, "state");
      rd(IN_FAULT_ADDR, 1'b1, 8'h00, "fault");
      for (k = 1; k < 16; k++) if (k == 1 || k > 5) rd(k[3:0], 1'b1, 8'h00, "spare");
      wr(4'h1, 8'hFF);
      wr(4'h2, 8'hFF);
      for (k = 6; k < 16; k++) wr(k[3:0], 8'h00);
      wr(OUT_ACTION_ADDR, 8'hC6);
      rd(IN_STATE_ADDR, 1'b1, 8'h00, "state");
      wr(OUT_ACTION_ADDR, 8'h08);
      idle(20);
      chk("on_seen", 8'h00, {7'h00, on_seen});
      rd(IN_FAULT_ADDR, 1'b1, {4'h0, FLT_NO_ACT}, "fault");
      tgt = next();
      wr(OUT_TARGET_ADDR, tgt);
      wr(OUT_SPEED_ADDR, next() | 8'h80);
      wr(OUT_FORCE_ADDR, 8'hFF);
      idle(20);
      chk("on_seen", 8'h00, {7'h00, on_seen});
      rd(IN_ECHO_ADDR, 1'b1, tgt, "echo");
      chk("cap", 8'hFF, cap);
      wr(OUT_ACTION_ADDR, 8'h01);
      wait_on();
      chk("dir", 8'h00, {7'h00, dir});
      poll(IN_STATE_ADDR, 8'h30, {2'b00, STA_DONE, 4'h0});
      rd(IN_POSITION_ADDR, 1'b1, POS_OPEN, "position");
      rd(IN_FAULT_ADDR, 1'b1, 8'h00, "fault");
      // Closing release cut short by dropping activate
      wr(OUT_ACTION_ADDR, 8'h11);
      wait_on();
      chk("dir", 8'h01, {7'h00, dir});
      rd(IN_FAULT_ADDR, 1'b1, {4'h0, FLT_RELEASING}, "fault");
      wr(OUT_ACTION_ADDR, 8'h00);
      idle(3);
      chk("motor_on", 8'h00, {7'h00, motor_on});
      rd(IN_FAULT_ADDR, 1'b1, {4'h0, FLT_RELEASING}, "fault");
      wr(OUT_ACTION_ADDR, 8'h01);
      poll(IN_STATE_ADDR, 8'h30, {2'b00, STA_DONE, 4'h0});
      rd(IN_FAULT_ADDR, 1'b1, 8'h00, "fault");
      for (k = 0; k < 2; k++) begin
         tgt = (k == 0) ? ((next() & 8'h7F) | 8'h20) : 8'h00;
         wr(OUT_ACTION_ADDR, 8'h01);
         wr(OUT_TARGET_ADDR, tgt);
         wr(OUT_ACTION_ADDR, 8'h09);
         poll(IN_STATE_ADDR, 8'hC0, {OBJ_AT, 6'h00});
         rd(IN_POSITION_ADDR, 1'b1, tgt, "position");
         rd(IN_CURRENT_ADDR, 1'b1, current, "current");
      end
      wr(OUT_ACTION_ADDR, 8'h01);
      obj_en = 1'b1;
      wr(OUT_FORCE_ADDR, 8'h80);
      wr(OUT_TARGET_ADDR, POS_CLOSED);
      chk("cap", 8'h80, cap);
      wr(OUT_ACTION_ADDR, 8'h09);
      poll(IN_STATE_ADDR, 8'hC0, {OBJ_CLOSE, 6'h00});
      rd(IN_POSITION_ADDR, 1'b1, obj_pos, "position");
      chk("motor_on", 8'h00, {7'h00, motor_on});
      @(posedge clk_in); #1;
      obj_en = 1'b0;
      poll(IN_STATE_ADDR, 8'hC0, {OBJ_AT, 6'h00});
      rd(IN_POSITION_ADDR, 1'b1, POS_CLOSED, "position");
      // Park near open: the slow release steps once per 256 cycles
      wr(OUT_TARGET_ADDR, 8'h02);
      wr(OUT_ACTION_ADDR, 8'h09);
      wait_on();
      poll(IN_STATE_ADDR, 8'hC0, {OBJ_AT, 6'h00});
      rd(IN_POSITION_ADDR, 1'b1, 8'h02, "position");
      wr(OUT_ACTION_ADDR, 8'h01);
      idle(3);
      chk("motor_on", 8'h00, {7'h00, motor_on});
      on_seen = 1'b0;
      idle(20);
      chk("on_seen", 8'h00, {7'h00, on_seen});
      // Opening release; direction change midway must be ignored
      wr(OUT_ACTION_ADDR, 8'h31);
      wait_on();
      chk("dir", 8'h00, {7'h00, dir});
      wr(OUT_ACTION_ADDR, 8'h11);
      idle(2);
      chk("dir", 8'h00, {7'h00, dir});
      poll(IN_FAULT_ADDR, 8'h0F, {4'h0, FLT_RELEASED});
      rd(IN_POSITION_ADDR, 1'b1, POS_OPEN, "position");
      wr(OUT_TARGET_ADDR, POS_CLOSED);
      on_seen = 1'b0;
      wr(OUT_ACTION_ADDR, 8'h19);
      idle(20);
      chk("on_seen", 8'h00, {7'h00, on_seen});
      wr(OUT_ACTION_ADDR, 8'h00);
      rd(IN_FAULT_ADDR, 1'b1, {4'h0, FLT_RELEASED}, "fault");
      wr(OUT_ACTION_ADDR, 8'h01);
      poll(IN_STATE_ADDR, 8'h30, {2'b00, STA_DONE, 4'h0});
      rd(IN_FAULT_ADDR, 1'b1, 8'h00, "fault");
      print_verdict();
   end
endmodule // tb
